// [logic/swd_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module swd_buf2
   import swd_pkg::*;
#(
   parameter int WIDTH = 16                          // Word width
)
(
   input wire logic clock,                           // Bus clock
   input wire logic rst,                             // Sync reset
   input wire logic [WIDTH-1:0] in_data,             // Word in
   input wire logic in_valid,                        // Word offered
   output logic in_ready,                            // Space available
   output logic [WIDTH-1:0] out_data,                // Word out, read from storage
   output logic out_valid,                           // Word present
   input wire logic out_ready                        // Consumer takes word
);
   logic [WIDTH-1:0] mem_r [2];                      // Storage
   logic wp_r;                                       // Write pointer
   logic rp_r;                                       // Read pointer
   logic [1:0] cnt_r;                                // Occupancy
   logic push;                                       // Write this cycle
   logic pop;                                        // Read this cycle

   assign push = in_valid && (cnt_r != 2'h2);
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];

   // Storage and pointers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wp_r] <= in_data;
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// [logic/swd_link.sv]
// Bit-level engine of the single-wire debug port.
// Assumes the pin is asynchronous; the command layer uses the word ports.
//
// What this block does
// - MSB first, sixteen cycles per bit
// - 512 idle cycles clears command register
// - Falling edge synchronised, one-to-two cycle lag
// - Host bit sampled ten cycles after start
// - Device leaves pin undriven on receive
// - One sent as speed-up pulse at seven
// - Zero held low thirteen cycles, then pulse
// - Dead or stolen cycles left to the command layer
// - Firmware background gating left to the command layer
// - All timing counted in bus cycles
// - Pin is pseudo-open-drain, both directions
// - Eight-bit opcode, then sixteen-bit fields
`timescale 1ns/1ps
module swd_link
   import swd_pkg::*;
(
   input wire logic clock,                           // Bus clock, 250 MHz
   input wire logic rst,                             // Sync reset, active high
   input wire logic debug_wire_pin_in,               // Pin level, asynchronous
   output logic debug_wire_pin_out,                  // Pin drive level
   output logic debug_wire_pin_oe,                   // Pin drive enable
   output logic [SWD_OPCODE_BITS-1:0] cmd_opcode,    // Command register
   output logic cmd_opcode_valid,                    // Opcode complete
   output logic [SWD_WORD_BITS-1:0] rx_word,         // Received word
   output logic rx_word_valid,                       // Received word ready
   input wire logic rx_word_ready,                   // Command layer takes word
   input wire logic [SWD_WORD_BITS-1:0] tx_word,     // Word to send
   input wire logic tx_word_valid,                   // Send word offered
   output logic tx_word_ready,                       // Send word accepted
   input wire logic [4:0] tx_bits,                   // Bits in send word
   output logic timeout_pulse,                       // Timeout happened
   output logic rx_stall                             // Receive buffer full
);
   // ****************************************
   // Derived counts
   // ****************************************
   localparam logic [SWD_CNT_W-1:0] SAMPLE_AT = SWD_CNT_W'(SWD_SAMPLE_CYCLE);
   localparam logic [SWD_CNT_W-1:0] ONE_AT = SWD_CNT_W'(SWD_ONE_PULSE_CYCLE);
   localparam logic [SWD_CNT_W-1:0] ZERO_END = SWD_CNT_W'(SWD_ZERO_LOW_CYCLES);
   localparam logic [SWD_CNT_W-1:0] PULSE_LEN = SWD_CNT_W'(SWD_PULSE_CYCLES);
   localparam logic [SWD_CNT_W-1:0] TMO_AT = SWD_CNT_W'(SWD_TIMEOUT_CYCLES - 1);
   localparam logic [SWD_CNT_W-1:0] BIT_END = SWD_CNT_W'(SWD_BIT_CYCLES);

   // ****************************************
   // Pin synchroniser and edge detect
   // ****************************************
   logic pin_s1_r;                                   // First stage
   logic pin_s2_r;                                   // Second stage
   logic pin_s3_r;                                   // Previous level
   logic fall;                                       // Host falling edge

   // Two flops before any logic reads the pin
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_s3_r <= 1'b1;
      end
      else
      begin
         pin_s1_r <= debug_wire_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // Edge seen only while device is not driving; the device's own low
   // drive and its release must never look like a host edge
   assign fall = pin_s3_r && !pin_s2_r && !debug_wire_pin_oe;

   // ****************************************
   // State and counters
   // ****************************************
   swd_state_type state_r;                           // Bit engine state
   logic [SWD_CNT_W-1:0] cyc_r;                      // Cycles into bit
   logic [SWD_CNT_W-1:0] idle_r;                     // Cycles since edge
   logic [3:0] rxcnt_r;                              // Received bits in word
   logic [SWD_WORD_BITS-1:0] rxsh_r;                 // Receive shifter
   logic [SWD_WORD_BITS-1:0] txsh_r;                 // Send shifter
   logic [4:0] txleft_r;                             // Bits left to send
   logic opc_done_r;                                 // Opcode already taken
   logic tx_bit;                                     // Current send bit
   logic tmo;                                        // Timeout condition
   logic sample;                                     // Sample strobe
   logic word_done;                                  // Receive word complete
   logic buf_in_ready;                               // Buffer has room

   assign tx_bit = txsh_r[SWD_WORD_BITS-1];
   assign tmo = (idle_r == TMO_AT) && !fall;
   assign sample = (state_r == SWD_RECV) && (cyc_r == SAMPLE_AT - 1'b1);
   assign word_done = sample && (opc_done_r ? (rxcnt_r == 4'hF) : (rxcnt_r == 4'h7));

   // Idle timer counts bus cycles between falling edges
   // It wraps after a timeout, so a silent host keeps being cleared
   always_ff @(posedge clock)
   begin
      if (rst || fall)
         idle_r <= '0;
      else if (idle_r != TMO_AT)
         idle_r <= idle_r + 1'b1;
      else
         idle_r <= '0;
   end

   // Bit engine state machine
   // Runs whatever the processor does; nothing here waits on it
   always_ff @(posedge clock)
   begin
      if (rst || tmo)
      begin
         state_r <= SWD_IDLE;
         cyc_r <= '0;
      end
      else
      begin
         unique case (state_r)
            SWD_IDLE:
            begin
               if (fall)
               begin
                  cyc_r <= '0;
                  // A pending send word turns the bit into a device bit
                  state_r <= (txleft_r != 5'h0) ? SWD_SEND : SWD_RECV;
               end
            end
            SWD_RECV:
            begin
               cyc_r <= cyc_r + 1'b1;
               if (cyc_r == SAMPLE_AT - 1'b1)
                  state_r <= SWD_WAIT;
            end
            SWD_SEND:
            begin
               cyc_r <= cyc_r + 1'b1;
               if (cyc_r == BIT_END - 1'b1)
                  state_r <= SWD_WAIT;
            end
            SWD_WAIT:
            begin
               // Wait for the line to return high before the next edge
               if (pin_s2_r)
                  state_r <= SWD_IDLE;
            end
            default:
               state_r <= SWD_IDLE;
         endcase
      end
   end

   // Pin drive for device-to-host bits; undriven otherwise
   // Registered, so decode glitches never reach the pin
   always_ff @(posedge clock)
   begin
      if (rst || state_r != SWD_SEND)
      begin
         debug_wire_pin_oe <= 1'b0;
         debug_wire_pin_out <= 1'b1;
      end
      else if (tx_bit)
      begin
         // Brief high pulse after host released the line
         debug_wire_pin_oe <= (cyc_r >= ONE_AT - 1'b1) &&
                              (cyc_r < ONE_AT - 1'b1 + PULSE_LEN);
         debug_wire_pin_out <= 1'b1;
      end
      else
      begin
         // Low for the hold time, then speed-up pulse high
         debug_wire_pin_oe <= (cyc_r < ZERO_END - 1'b1 + PULSE_LEN);
         debug_wire_pin_out <= (cyc_r >= ZERO_END - 1'b1);
      end
   end

   // Receive shifter and bit counter
   // Shifted only at the sample strobe, so edge jitter does no harm
   always_ff @(posedge clock)
   begin
      if (rst || tmo)
      begin
         rxsh_r <= '0;
         rxcnt_r <= 4'h0;
         opc_done_r <= 1'b0;
      end
      else if (sample)
      begin
         rxsh_r <= {rxsh_r[SWD_WORD_BITS-2:0], pin_s2_r};
         if (word_done)
         begin
            rxcnt_r <= 4'h0;
            opc_done_r <= 1'b1;
         end
         else
            rxcnt_r <= rxcnt_r + 1'b1;
      end
   end

   // Command register, cleared on timeout
   // The opcode is handed over whole; the command layer picks dead or
   // stolen cycles and runs firmware opcodes only in background
   always_ff @(posedge clock)
   begin
      if (rst || tmo)
      begin
         cmd_opcode <= '0;
         cmd_opcode_valid <= 1'b0;
      end
      else if (word_done && !opc_done_r)
      begin
         cmd_opcode <= {rxsh_r[SWD_OPCODE_BITS-2:0], pin_s2_r};
         cmd_opcode_valid <= 1'b1;
      end
   end

   // Send shifter loaded from command layer
   always_ff @(posedge clock)
   begin
      if (rst || tmo)
      begin
         txsh_r <= '0;
         txleft_r <= 5'h0;
         tx_word_ready <= 1'b0;
      end
      else
      begin
         tx_word_ready <= 1'b0;
         if (txleft_r == 5'h0 && tx_word_valid && !tx_word_ready && state_r == SWD_IDLE)
         begin
            txsh_r <= tx_word;
            txleft_r <= tx_bits;
            tx_word_ready <= 1'b1;
         end
         else if (state_r == SWD_SEND && cyc_r == BIT_END - 1'b1)
         begin
            txsh_r <= {txsh_r[SWD_WORD_BITS-2:0], 1'b0};
            txleft_r <= txleft_r - 5'h1;
         end
      end
   end

   // Status pulse and stall flag
   // rx_stall warns the command layer before a fourth word is lost
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timeout_pulse <= 1'b0;
         rx_stall <= 1'b0;
      end
      else
      begin
         timeout_pulse <= tmo;
         rx_stall <= !buf_in_ready;
      end
   end

   // ****************************************
   // Received word buffer
   // ****************************************
   logic [SWD_WORD_BITS-1:0] buf_data;               // Buffer head
   logic buf_valid;                                  // Buffer not empty
   logic [SWD_WORD_BITS-1:0] rxo_r;                  // Registered word out
   logic rxv_r;                                      // Registered valid

   swd_buf2 #(.WIDTH(SWD_WORD_BITS)) u_buf (
      .clock(clock),
      .rst(rst),
      .in_data({rxsh_r[SWD_WORD_BITS-2:0], pin_s2_r}),
      .in_valid(word_done && opc_done_r),
      .in_ready(buf_in_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(!rxv_r || rx_word_ready)
   );

   // Output register stage so the port comes from a flop
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rxo_r <= '0;
         rxv_r <= 1'b0;
      end
      else if (!rxv_r || rx_word_ready)
      begin
         rxo_r <= buf_data;
         rxv_r <= buf_valid;
      end
   end

   assign rx_word = rxo_r;
   assign rx_word_valid = rxv_r;
endmodule

// [logic/swd_pkg.sv]
// Constants shared by the single-wire debug bit link.
// Assumes a 250 MHz bus clock; all bit timing is counted in bus cycles.
package swd_pkg;
   // ****************************************
   // Bit timing, in bus-clock cycles
   // ****************************************
   localparam int SWD_BIT_CYCLES = 16;               // Nominal bit period
   localparam int SWD_TIMEOUT_CYCLES = 512;          // Idle cycles before timeout
   localparam int SWD_SAMPLE_CYCLE = 10;             // Host bit sampled here
   localparam int SWD_ONE_PULSE_CYCLE = 7;           // Speed-up pulse for a one
   localparam int SWD_ZERO_LOW_CYCLES = 13;          // Low hold for a zero
   localparam int SWD_PULSE_CYCLES = 1;              // Width of speed-up pulse
   localparam int SWD_CMD_GAP_CYCLES = 150;          // Host gap after a command
   // ****************************************
   // Command framing
   // ****************************************
   localparam int SWD_OPCODE_BITS = 8;               // Opcode length
   localparam int SWD_WORD_BITS = 16;                // Address or data length
   localparam int SWD_CNT_W = 10;                    // Cycle counter width
   // ****************************************
   // Bit engine states
   // ****************************************
   typedef enum logic [3:0] {
      SWD_IDLE = 4'h1,                               // Waiting for host edge
      SWD_RECV = 4'h2,                               // Host to device bit
      SWD_SEND = 4'h4,                               // Device to host bit
      SWD_WAIT = 4'h8                                // Wait for pin to rise
   } swd_state_type;
endpackage

// [sim/swd_host.sv]
// Host model of the debug wire; it starts every bit.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module swd_host
(
   input wire logic clock, // Bus clock
   input wire logic pin, // Resolved wire level
   output logic h_oe, // Host drives wire
   output logic h_lvl // Host drive level
);
   initial
   begin
      h_oe = 1'b0;
      h_lvl = 1'b1;
   end
   // Write one bit: short low for a one, long low for a zero
   task automatic send_bit(input logic b);
      @(posedge clock);
      h_oe <= 1'b1;
      h_lvl <= 1'b0;
      repeat (b ? 3 : 15) @(posedge clock);
      h_lvl <= 1'b1; // Driven high to speed the edge
      repeat (b ? 17 : 5) @(posedge clock);
   endtask
   // Read one bit: four low cycles, release, sample at ten
   task automatic read_bit(output logic b);
      @(posedge clock);
      h_oe <= 1'b1;
      h_lvl <= 1'b0;
      // Four low cycles: the device needs two, and its own low drive for a
      // zero starts as the host lets go, so the line shows no glitch
      repeat (4) @(posedge clock);
      h_oe <= 1'b0;
      repeat (6) @(posedge clock);
      b = pin;
      repeat (14) @(posedge clock);
   endtask
endmodule

// [sim/swd_link_checker.sv]
// Assertions on the ports of the debug bit link.
// Assumes one bus clock and a synchronous active-high reset.
`timescale 1ns/1ps
module swd_link_checker
   import swd_pkg::*;
(
   input wire logic clock, // Bus clock
   input wire logic rst, // Reset
   input wire logic debug_wire_pin_in, // Pin level
   input wire logic debug_wire_pin_out, // Drive level
   input wire logic debug_wire_pin_oe, // Drive enable
   input wire logic [SWD_OPCODE_BITS-1:0] cmd_opcode, // Command
   input wire logic cmd_opcode_valid, // Command valid
   input wire logic [SWD_WORD_BITS-1:0] rx_word, // Rx word
   input wire logic rx_word_valid, // Rx valid
   input wire logic rx_word_ready, // Rx taken
   input wire logic [SWD_WORD_BITS-1:0] tx_word, // Tx word
   input wire logic tx_word_valid, // Tx offered
   input wire logic tx_word_ready, // Tx loaded
   input wire logic [4:0] tx_bits, // Tx bit count
   input wire logic timeout_pulse, // Timeout
   input wire logic rx_stall // Buffer full
);
   // ****************************************
   // Cycles since the last host falling edge or timeout pulse
   // ****************************************
   logic pin_d_r; // Pin one cycle ago
   logic [9:0] idle_cnt_r; // Saturating idle count
   // Falls made by the device itself do not restart the count
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pin_d_r <= 1'b1;
         idle_cnt_r <= 10'h000;
      end
      else
      begin
         pin_d_r <= debug_wire_pin_in;
         if ((pin_d_r && !debug_wire_pin_in && !debug_wire_pin_oe) || timeout_pulse)
            idle_cnt_r <= 10'h000;
         else if (idle_cnt_r != 10'h3FF)
            idle_cnt_r <= idle_cnt_r + 10'h001;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_timeout_count: assert property (timeout_pulse |-> idle_cnt_r inside {[10'h1FE:10'h208]})
      else $error("timeout at wrong idle count");
   a_timeout_clear: assert property (timeout_pulse |=> !cmd_opcode_valid && cmd_opcode == 8'h00)
      else $error("command kept after timeout");
   a_timeout_once: assert property (timeout_pulse |=> !timeout_pulse)
      else $error("timeout pulse too long");
   a_one_pulse: assert property ($rose(debug_wire_pin_oe) && debug_wire_pin_out |->
      idle_cnt_r inside {[10'h009:10'h00B]} ##1 !debug_wire_pin_oe)
      else $error("one pulse misplaced");
   a_zero_hold: assert property ($rose(debug_wire_pin_oe) && !debug_wire_pin_out |->
      idle_cnt_r inside {[10'h003:10'h005]} ##1 (debug_wire_pin_oe && !debug_wire_pin_out)[*8]
      ##1 (debug_wire_pin_oe && !debug_wire_pin_out)[*3]
      ##1 (debug_wire_pin_oe && debug_wire_pin_out)
      ##1 !debug_wire_pin_oe)
      else $error("zero bit shape wrong");
   a_drive_window: assert property ($rose(debug_wire_pin_oe) |-> idle_cnt_r <= 10'h00C)
      else $error("drive outside a read bit");
   a_rx_hold: assert property (rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word))
      else $error("rx word lost before taken");
   a_stall_valid: assert property (rx_stall |-> rx_word_valid)
      else $error("stall with empty output");
   a_opcode_stable: assert property (cmd_opcode_valid && $past(cmd_opcode_valid) |->
      $stable(cmd_opcode))
      else $error("command changed while valid");
   c_timeout: cover property (timeout_pulse);
   c_stall: cover property (rx_stall);
   c_one: cover property ($rose(debug_wire_pin_oe) && debug_wire_pin_out);
   c_zero: cover property ($rose(debug_wire_pin_oe) && !debug_wire_pin_out);
endmodule
bind swd_link swd_link_checker chk (.clock, .rst, .debug_wire_pin_in, .debug_wire_pin_out,
   .debug_wire_pin_oe, .cmd_opcode, .cmd_opcode_valid, .rx_word, .rx_word_valid, .rx_word_ready,
   .tx_word, .tx_word_valid, .tx_word_ready, .tx_bits, .timeout_pulse, .rx_stall);

// [sim/swd_link_test.sv]
// Self-checking bench of the debug bit link with a host model.
// Assumes the checker is bound to the link by its own file.
`timescale 1ns/1ps
module swd_link_test;
   import swd_pkg::*;
   typedef struct {logic [7:0] op; logic [15:0] w; logic [15:0] tw; logic [4:0] tn;} swd_row_type;
   logic clock, rst, pin, d_out, d_oe, h_oe, h_lvl, op_v, rx_v, rx_rdy, tx_v, tx_rdy, tmo, stall;
   logic [7:0] op;
   logic [15:0] rx_w, tx_w, got;
   logic [4:0] tx_n;
   int mismatches = 0;
   int check_count = 0;
   int wait_n; // Cycles spent waiting for the timeout pulse
   swd_row_type rows [4] = '{'{8'hE4, 16'hFF01, 16'hC000, 5'h08},
      '{8'hC4, 16'h8000, 16'hA5A5, 5'h10}, '{8'h90, 16'h0000, 16'h8000, 5'h01},
      '{8'hCC, 16'hFFFF, 16'h0001, 5'h10}};
   // Pseudo-open-drain wire with pull-up
   assign pin = d_oe ? d_out : (h_oe ? h_lvl : 1'b1);
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   swd_link dut (.clock(clock), .rst(rst), .debug_wire_pin_in(pin), .debug_wire_pin_out(d_out),
      .debug_wire_pin_oe(d_oe), .cmd_opcode(op), .cmd_opcode_valid(op_v), .rx_word(rx_w),
      .rx_word_valid(rx_v), .rx_word_ready(rx_rdy), .tx_word(tx_w), .tx_word_valid(tx_v),
      .tx_word_ready(tx_rdy), .tx_bits(tx_n), .timeout_pulse(tmo), .rx_stall(stall));
   swd_host host (.clock(clock), .pin(pin), .h_oe(h_oe), .h_lvl(h_lvl));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send_op(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) host.send_bit(v[i]);
   endtask
   task automatic send_word(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) host.send_bit(v[i]);
   endtask
   task automatic read_n(input int n, output logic [15:0] v);
      logic b;
      v = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         host.read_bit(b);
         v = {v[14:0], b};
      end
   endtask
   task automatic take_word;
      @(posedge clock);
      rx_rdy <= 1'b1;
      @(posedge clock);
      rx_rdy <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial
   begin
      repeat (40000) @(posedge clock);
      mismatches++;
      give_verdict;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      rx_rdy = 1'b0;
      tx_w = 16'h0000;
      tx_v = 1'b0;
      tx_n = 5'h00;
      repeat (12) @(posedge clock);
      check(d_oe, 16'h0000);
      check(rx_v | op_v, 16'h0000);
      rst <= 1'b0;
      // Rows: opcode, word in, word out, then idle into timeout
      foreach (rows[i])
      begin
         send_op(rows[i].op);
         repeat (4) @(posedge clock);
         check(op, rows[i].op);
         send_word(rows[i].w);
         repeat (4) @(posedge clock);
         check(rx_w, rows[i].w);
         take_word;
         repeat (SWD_CMD_GAP_CYCLES) @(posedge clock);
         tx_w <= rows[i].tw;
         tx_n <= rows[i].tn;
         tx_v <= 1'b1;
         for (int k = 0; k < 50 && tx_rdy !== 1'b1; k++) @(posedge clock);
         check(tx_rdy, 16'h0001);
         tx_v <= 1'b0;
         read_n(rows[i].tn, got);
         check(got, rows[i].tw >> (16 - rows[i].tn));
         repeat (600) @(posedge clock);
         check(op_v, 16'h0000);
      end
      // Stall: three words fill output stage and buffer, nobody takes them
      send_op(8'hE0);
      send_word(16'h1234);
      send_word(16'hFEDC);
      send_word(16'h5A5A);
      repeat (4) @(posedge clock);
      check(stall, 16'h0001);
      check(rx_w, 16'h1234);
      take_word;
      @(posedge clock);
      check(rx_w, 16'hFEDC);
      take_word;
      @(posedge clock);
      check(rx_w, 16'h5A5A);
      check(stall, 16'h0000);
      check(rx_v, 16'h0001);
      take_word;
      @(posedge clock);
      check(rx_v, 16'h0000);
      // Timeout in mid-opcode restarts the bit count
      repeat (600) @(posedge clock);
      repeat (5) host.send_bit(1'b1);
      // The last host bit took 20 cycles; the pulse lands 512 to 520 after its edge
      for (wait_n = 0; wait_n < 600 && tmo !== 1'b1; wait_n++) @(posedge clock);
      check(tmo, 16'h0001);
      check(wait_n + 20 >= SWD_TIMEOUT_CYCLES, 16'h0001);
      check(wait_n + 20 <= SWD_TIMEOUT_CYCLES + 8, 16'h0001);
      send_op(8'h3C);
      repeat (4) @(posedge clock);
      check(op, 16'h003C);
      // Reset in mid-word: state cleared, the next bits form an opcode
      repeat (3) host.send_bit(1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      check(d_oe, 16'h0000);
      check(op_v, 16'h0000);
      check(op, 16'h0000);
      rst <= 1'b0;
      send_op(8'hA5);
      repeat (4) @(posedge clock);
      check(op, 16'h00A5);
      give_verdict;
   end
endmodule
